// >>> core/pgom_pkg.sv
// Package with the register map, field positions and reset values of the power-good mask.
package pgom_pkg;
   localparam logic [7:0] MASK_A_ADDR = 8'haa;
   localparam logic [7:0] MASK_B_ADDR = 8'hab;
   // Mask A fields.
   localparam int STEP_DOWN_ONE_IGNORE = 0;
   localparam int STEP_DOWN_SIX_IGNORE = 5;
   localparam int SWITCH_GROUP_A_ONE_IGNORE = 6;
   localparam int AUX_LDO_TWO_IGNORE = 7;
   // Mask B fields.
   localparam int AUX_LDO_THREE_IGNORE = 0;
   localparam int SWITCH_GROUP_B_ONE_IGNORE = 1;
   localparam int SHARED_SWITCH_OR_LDO_IGNORE = 2;
   localparam int TERMINATION_RAIL_IGNORE = 3;
   localparam int CONTROL_INPUT_ONE_IGNORE = 4;
   localparam int CONTROL_INPUT_FIVE_IGNORE = 7;
   // Default factory images; the real values are set per variant at the top level.
   localparam logic [7:0] MASK_A_RESET = 8'hff;
   localparam logic [7:0] MASK_B_RESET = 8'hff;
   localparam logic [1:0] CTL36_RESET = 2'h3;
   localparam int SYNC_STAGES = 3;
   localparam int NUM_SOURCES = 18;
endpackage

// >>> core/pgom_sync_if.sv
// Interface carrying raw and synchronised source levels between the top and the synchroniser.
interface pgom_sync_if #(parameter int W = 18);
   logic [W-1:0] raw;
   logic [W-1:0] stable;
   modport top (output raw, input stable);
   modport sync (input raw, output stable);
endinterface

// >>> core/pgom_sync.sv
// Three-stage synchroniser that accepts a change once the last two stages agree.
module pgom_sync #(
   parameter int W = 18,
   parameter logic [17:0] INIT = 18'h00000
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic arst_n,
   // Source levels.
   pgom_sync_if.sync port
);
   logic [W-1:0] s1_q, s2_q, s3_q, st_q;
   logic [W-1:0] s1_d, s2_d, s3_d, st_d;

   always_comb begin
      s1_d = port.raw;
      s2_d = s1_q;
      s3_d = s2_q;
      st_d = st_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            st_d[i] = s3_q[i];
         end
      end
   end

   // Sources start as not good so the output cannot glitch high out of reset.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= INIT[W-1:0];
         s2_q <= INIT[W-1:0];
         s3_q <= INIT[W-1:0];
         st_q <= INIT[W-1:0];
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         st_q <= st_d;
      end
   end

   assign port.stable = st_q;
endmodule

// >>> core/pgom_top.sv
// Power-good mask logic for the third power-good output pin.
// Operation
// (R1) Mask A bits 0-5 gate step-down one..six.
// (R2) Mask A bit 6 gates load switch one.
// (R3) Mask A bit 7 gates LDO two.
// (R4) Mask B bit 0 gates LDO three.
// (R5) Mask B bit 1 gates group-B switch one.
// (R6) Mask B bit 2 gates variant-shared source.
// (R7) Mask B bit 3 gates termination rail.
// (R8) Mask B bits 4-7 gate control inputs 1,2,4,5.
// (R9) Masks reset to factory values, stay read/write.
// (R10) Separate bits gate control inputs three, six.
// (R11) Output good only when all unmasked sources good.
module pgom_top #(
   parameter logic [7:0] MASK_A_INIT = pgom_pkg::MASK_A_RESET,
   parameter logic [7:0] MASK_B_INIT = pgom_pkg::MASK_B_RESET,
   parameter logic [1:0] CTL36_INIT = pgom_pkg::CTL36_RESET
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic arst_n,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Masks for control inputs three and six held elsewhere in the device.
   input wire logic control_input_three_ignore,
   input wire logic control_input_six_ignore,
   // Source power-good levels.
   input wire logic [5:0] step_down_pg,
   input wire logic switch_group_a_one_pg,
   input wire logic aux_ldo_two_pg,
   input wire logic aux_ldo_three_pg,
   input wire logic switch_group_b_one_pg,
   input wire logic shared_switch_or_ldo_pg,
   input wire logic termination_rail_pg,
   input wire logic [3:0] control_input_1245,
   input wire logic control_input_three,
   input wire logic control_input_six,
   // Power-good output and current mask images.
   output logic third_pg_output_pin,
   output logic [7:0] mask_a,
   output logic [7:0] mask_b
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] mask_a_q, mask_a_d, mask_b_q, mask_b_d, rdata_q, rdata_d;
   logic [1:0] ctl36_q, ctl36_d;
   logic pg_q, pg_d;
   logic [17:0] ign;
   pgom_sync_if #(.W(pgom_pkg::NUM_SOURCES)) sif ();

   function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] ma,
                                            input logic [7:0] mb);
      read_mux = 8'h00;
      if (a == pgom_pkg::MASK_A_ADDR) begin
         read_mux = ma;
      end else if (a == pgom_pkg::MASK_B_ADDR) begin
         read_mux = mb;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Sources from the rails and pins are all asynchronous to the logic clock.
   assign sif.raw = {control_input_six, control_input_three, control_input_1245,
                     termination_rail_pg, shared_switch_or_ldo_pg, switch_group_b_one_pg,
                     aux_ldo_three_pg, aux_ldo_two_pg, switch_group_a_one_pg, step_down_pg};

   pgom_sync #(.W(pgom_pkg::NUM_SOURCES), .INIT(18'h00000)) u_sync (
      .clock(clock),
      .arst_n(arst_n),
      .port(sif.sync)
   );

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      mask_a_d = mask_a_q;
      mask_b_d = mask_b_q;
      if (reg_wr && reg_addr == pgom_pkg::MASK_A_ADDR) begin
         mask_a_d = reg_wdata; // R9
      end
      if (reg_wr && reg_addr == pgom_pkg::MASK_B_ADDR) begin
         mask_b_d = reg_wdata; // R9
      end
      rdata_d = read_mux(reg_addr, mask_a_d, mask_b_d);
      ctl36_d = {control_input_six_ignore, control_input_three_ignore};
   end

   // Ignore vector in the same order as the synchronised sources.
   always_comb begin
      ign = 18'h00000;
      ign[5:0] = mask_a_q[pgom_pkg::STEP_DOWN_SIX_IGNORE:pgom_pkg::STEP_DOWN_ONE_IGNORE]; // R1
      ign[6] = mask_a_q[pgom_pkg::SWITCH_GROUP_A_ONE_IGNORE]; // R2
      ign[7] = mask_a_q[pgom_pkg::AUX_LDO_TWO_IGNORE]; // R3
      ign[8] = mask_b_q[pgom_pkg::AUX_LDO_THREE_IGNORE]; // R4
      ign[9] = mask_b_q[pgom_pkg::SWITCH_GROUP_B_ONE_IGNORE]; // R5
      ign[10] = mask_b_q[pgom_pkg::SHARED_SWITCH_OR_LDO_IGNORE]; // R6
      ign[11] = mask_b_q[pgom_pkg::TERMINATION_RAIL_IGNORE]; // R7
      ign[15:12] =
         mask_b_q[pgom_pkg::CONTROL_INPUT_FIVE_IGNORE:pgom_pkg::CONTROL_INPUT_ONE_IGNORE]; // R8
      ign[17:16] = ctl36_q; // R10
      // Masked sources are forced good so their level cannot matter.
      pg_d = &(sif.stable | ign); // R11
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The variant image is a parameter, so reset loads a constant as it must.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mask_a_q <= MASK_A_INIT; // R9
         mask_b_q <= MASK_B_INIT; // R9
         ctl36_q <= CTL36_INIT;
         rdata_q <= 8'h00;
         pg_q <= 1'b0;
      end else begin
         mask_a_q <= mask_a_d;
         mask_b_q <= mask_b_d;
         ctl36_q <= ctl36_d;
         rdata_q <= rdata_d;
         pg_q <= pg_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign third_pg_output_pin = pg_q;
   assign mask_a = mask_a_q;
   assign mask_b = mask_b_q;
endmodule

// >>> dv/pgom_monitor.sv
// Checker of the mask registers and the power-good output.
module pgom_monitor (
   // Clock and reset.
   input wire logic clock,
   input wire logic arst_n,
   // Register port and external mask bits.
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic control_input_three_ignore,
   input wire logic control_input_six_ignore,
   // Sources, output and mask images.
   input wire logic [5:0] step_down_pg,
   input wire logic third_pg_output_pin,
   input wire logic [7:0] mask_a,
   input wire logic [7:0] mask_b
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   property p_wa; reg_wr && reg_addr == 8'haa |=> mask_a == $past(reg_wdata); endproperty
   property p_wb; reg_wr && reg_addr == 8'hab |=> mask_b == $past(reg_wdata); endproperty
   property p_ka; !(reg_wr && reg_addr == 8'haa) |=> $stable(mask_a); endproperty
   property p_ra; reg_addr == 8'haa |=> reg_rdata == mask_a; endproperty
   property p_rb; reg_addr == 8'hab |=> reg_rdata == mask_b; endproperty
   property p_ru; reg_addr != 8'haa && reg_addr != 8'hab |=> reg_rdata == 8'h00; endproperty
   // Source levels are synchronised, so only settled windows are judged.
   property p_hi;
      (mask_a == 8'hff && mask_b == 8'hff && control_input_three_ignore
       && control_input_six_ignore) [*8] |=> third_pg_output_pin;
   endproperty
   property p_lo; (!mask_a[0] && !step_down_pg[0]) [*8] |=> !third_pg_output_pin; endproperty
   a_wa: assert property (p_wa) else $error("mask a write lost");
   a_wb: assert property (p_wb) else $error("mask b write lost");
   a_ka: assert property (p_ka) else $error("mask a changed");
   a_ra: assert property (p_ra) else $error("mask a read wrong");
   a_rb: assert property (p_rb) else $error("mask b read wrong");
   a_ru: assert property (p_ru) else $error("unmapped read not zero");
   a_hi: assert property (p_hi) else $error("all masked but not good");
   a_lo: assert property (p_lo) else $error("included fault ignored");
   c_wb: cover property (reg_wr && reg_addr == 8'hab);
   c_hi: cover property (third_pg_output_pin);
   c_lo: cover property (!third_pg_output_pin && !mask_a[0]);
endmodule

// >>> dv/power_good_output_mask_bench.sv
// Self-checking bench of the power-good mask block.
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module power_good_output_mask_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic [7:0] reg_addr = 8'haa;
   logic [7:0] reg_wdata = 8'h00;
   logic [1:0] ig = 2'h3;
   logic [17:0] s = '1;
   logic [17:0] m;
   logic [15:0] r = 16'hbf5b;
   logic [7:0] rd, ma, mb;
   logic pin;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   always #20 clock = ~clock;
   pgom_top #(.MASK_A_INIT(8'he0), .MASK_B_INIT(8'hbf), .CTL36_INIT(2'h3)) i_dut (
      .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(rd), .control_input_three_ignore(ig[0]),
      .control_input_six_ignore(ig[1]), .step_down_pg(s[5:0]), .switch_group_a_one_pg(s[6]),
      .aux_ldo_two_pg(s[7]), .aux_ldo_three_pg(s[8]), .switch_group_b_one_pg(s[9]),
      .shared_switch_or_ldo_pg(s[10]), .termination_rail_pg(s[11]),
      .control_input_1245(s[15:12]), .control_input_three(s[16]), .control_input_six(s[17]),
      .third_pg_output_pin(pin), .mask_a(ma), .mask_b(mb));
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic wrap_up;
      if (failures == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
   endtask
   // Writes to an unmapped place ride along each update to prove they are dropped.
   task automatic apply(input logic [17:0] mk, input logic [17:0] src);
      wr(8'haa, mk[7:0]);
      wr(8'hab, mk[15:8]);
      wr(8'hac, ~mk[7:0]);
      reg_wr = 1'b0;
      ig = mk[17:16];
      s = src;
      repeat (8) @(negedge clock);
      `CHK("rdata_unmapped", 8'h00, rd)
      `CHK("mask_a", mk[7:0], ma)
      `CHK("mask_b", mk[15:8], mb)
      `CHK("pg_out", &(mk | src), pin)
      reg_addr = 8'hab;
      @(negedge clock);
      `CHK("rdata_b", mk[15:8], rd)
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         wrap_up;
      end
   end
   initial begin
      repeat (4) @(negedge clock);
      arst_n = 1'b1;
      @(negedge clock);
      `CHK("reset_a", 8'he0, ma)
      `CHK("reset_b", 8'hbf, mb)
      `CHK("rdata_a", 8'he0, rd)
      for (int n = 0; n < 60; n++) begin
         if (n < 36) begin
            m = ~(18'h1 << n[5:1]) | (18'(n[0]) << n[5:1]);
            apply(m, ~(18'h1 << n[5:1]));
         end else begin
            r = lfsr(r);
            m = {r[1:0], r};
            r = lfsr(r);
            apply(m, {r[3:2], r} | {r, r[15:14]});
         end
      end
      wrap_up;
   end
endmodule
bind pgom_top pgom_monitor i_mon (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .control_input_three_ignore(control_input_three_ignore),
   .control_input_six_ignore(control_input_six_ignore), .step_down_pg(step_down_pg),
   .third_pg_output_pin(third_pg_output_pin), .mask_a(mask_a), .mask_b(mask_b));
